// >>> system_control_instruction_unit.sv
// System-control instruction unit of one processor unit of the core.
// Executes call, return, jump, computed branch, delay, no-operation and
// global interrupt enable/disable, and owns PC, SP, ACC, flags and the
// return-address store. Assumes a decoder presents one instruction at a time
// on the issue port, and that i_instr_en is a one-cycle enable marking each
// instruction cycle of this processor unit, made on the same clock.
//
// Overview of operation
// - Call pushes next address, jumps, SP plus two.
// - Jump loads any program address into PC.
// - Immediate delay lasts immediate plus one cycles.
// - Accumulator delay lasts accumulator plus one cycles.
// - Memory delay lasts memory byte plus one cycles.
// - Every delay run outside single-unit mode leaves the accumulator at zero unless an outside write lands in its last cycle.
// - Delay counts this unit's instruction cycles.
// - Accumulator counts delay; writes change its length.
// - Delays unavailable in single-unit mode.
// - Return-with-value loads accumulator, then returns.
// - Return drops SP by two, reloads PC.
// - Interrupt return also sets global enable.
// - Computed branch adds accumulator to PC.
// - Interrupt enable lets requests reach unit zero.
// - Interrupt disable blocks requests to unit zero.
// - No instruction here touches Z, C, AC, OV.
// - Jump and call take two cycles, delays N+1, others one.
`timescale 1ns/1ps

module system_control_instruction_unit
  import sys_ctrl_pkg::*;
(
  input  wire logic              i_core_clk,     // Core clock, 125 MHz.
  input  wire logic              i_rst_n,        // Synchronous reset, active low.
  input  wire logic              i_instr_en,     // Instruction-cycle enable of this unit.
  input  wire logic              i_single_unit,  // High when only one processor unit runs.
  input  wire logic              i_issue,        // Decoder offers an instruction.
  input  wire instr_t            i_instr,        // The offered instruction.
  input  wire logic              i_acc_wr,       // Other logic writes the accumulator.
  input  wire logic [DATA_W-1:0] i_acc_wdata,    // Value for that write.
  input  wire logic              i_flags_wr,     // Other instructions write the flags.
  input  wire flags_t            i_flags_wdata,  // Value for that write.
  output logic                   o_ready,        // Unit can take an instruction this cycle.
  output logic                   o_retire,       // One-cycle pulse when an instruction ends.
  output logic                   o_unsupported,  // One-cycle pulse: delay refused.
  output logic [PC_W-1:0]        o_pc,           // Program counter.
  output logic [DATA_W-1:0]      o_sp,           // Stack pointer.
  output logic [DATA_W-1:0]      o_acc,          // Accumulator.
  output flags_t                 o_flags,        // Z, C, AC, OV.
  output logic                   o_gie           // Global interrupt enable toward processor_unit_zero.
);

  // Whole state of the unit, registered as one word.
  typedef struct packed {
    state_t                            st;        // Execution state.
    logic                              ready;     // Issue port open.
    logic                              retire;    // Completion pulse.
    logic                              unsup;     // Refusal pulse.
    logic [PC_W-1:0]                   pc;        // Program counter.
    logic [DATA_W-1:0]                 sp;        // Stack pointer.
    logic [DATA_W-1:0]                 acc;       // Accumulator, also the delay counter.
    flags_t                            flags;     // Arithmetic flags.
    logic                              gie;       // Global interrupt enable.
    logic [1:0]                        extra;     // Extra cycles left for a two-cycle op.
    logic [STACK_WORDS-1:0][PC_W-1:0]  stack;     // Return-address store.
  } unit_t;

  unit_t r;        // Registered state.
  unit_t next_r;   // Next state.

  // Issue is taken only on an instruction cycle while the port is open.
  logic                   take;      // Instruction accepted this cycle.
  logic [STACK_IDX_W-1:0] push_idx;  // Entry written by a call.
  logic [DATA_W-1:0]      pop_sp;    // Stack pointer after a return.
  logic [STACK_IDX_W-1:0] pop_idx;   // Entry read by a return.
  logic [PC_W-1:0]        pc_next;   // Address of the following instruction.
  logic [DATA_W-1:0]      dly_cnt;   // Count N named by a delay at issue.

  // Address arithmetic shared by the instruction cases.
  always_comb
  begin
    take     = i_issue && i_instr_en && r.ready;
    push_idx = r.sp[SP_IDX_LSB +: STACK_IDX_W];
    pop_sp   = r.sp - SP_STEP;
    pop_idx  = pop_sp[SP_IDX_LSB +: STACK_IDX_W];
    pc_next  = r.pc + PC_STEP;
    // The count source depends on the delay form; the accumulator form keeps its value.
    case (i_instr.op)
      OP_DELAY_IMM: dly_cnt = i_instr.imm;
      OP_DELAY_MEM: dly_cnt = i_instr.mem;
      default:      dly_cnt = r.acc;
    endcase
  end

  // Next-state logic: decode at issue, then count out two-cycle ops and delays.
  always_comb
  begin
    next_r        = r;
    // Pulses last one core clock.
    next_r.retire = 1'b0;
    next_r.unsup  = 1'b0;

    // Flags follow only the other instruction groups; nothing below writes them.
    if (i_flags_wr)
    begin
      next_r.flags = i_flags_wdata;
    end

    case (r.st)
      ST_IDLE:
      begin
        if (take)
        begin
          case (i_instr.op)
            OP_NOP:
            begin
              // Only the program counter moves.
              next_r.pc     = pc_next;
              next_r.retire = 1'b1;
            end
            OP_CALL:
            begin
              // Push the return address, branch, grow the stack by two.
              next_r.stack[push_idx] = pc_next;
              next_r.pc              = i_instr.target;
              next_r.sp              = r.sp + SP_STEP;
              next_r.extra           = EXTRA_2T;
              next_r.ready           = 1'b0;
              next_r.st              = ST_SECOND;
            end
            OP_JUMP:
            begin
              // Full-width target, no relative limit.
              next_r.pc    = i_instr.target;
              next_r.extra = EXTRA_2T;
              next_r.ready = 1'b0;
              next_r.st    = ST_SECOND;
            end
            OP_DELAY_IMM,
            OP_DELAY_ACC,
            OP_DELAY_MEM:
            begin
              if (i_single_unit)
              begin
                // Refused: behaves as a no-operation and reports it.
                next_r.pc     = pc_next;
                next_r.unsup  = 1'b1;
                next_r.retire = 1'b1;
              end
              else
              begin
                // The issue cycle is the first of the N+1 cycles, so a count of
                // zero ends here and any other count leaves N cycles to wait.
                next_r.pc = pc_next;
                if (dly_cnt == ACC_ZERO)
                begin
                  // Nothing left to count: finish like a one-cycle op.
                  next_r.acc    = ACC_ZERO;
                  next_r.retire = 1'b1;
                end
                else
                begin
                  // The accumulator holds the remaining cycles from here on.
                  next_r.acc   = dly_cnt;
                  next_r.ready = 1'b0;
                  next_r.st    = ST_DELAY;
                end
              end
            end
            OP_RET_IMM:
            begin
              // Immediate into the accumulator, then a plain return.
              next_r.acc    = i_instr.imm;
              next_r.sp     = pop_sp;
              next_r.pc     = r.stack[pop_idx];
              next_r.retire = 1'b1;
            end
            OP_RET:
            begin
              // Shrink the stack first, then reload from the new top.
              next_r.sp     = pop_sp;
              next_r.pc     = r.stack[pop_idx];
              next_r.retire = 1'b1;
            end
            OP_RET_INT:
            begin
              // Return from service and reopen interrupts in the same step.
              next_r.sp     = pop_sp;
              next_r.pc     = r.stack[pop_idx];
              next_r.gie    = 1'b1;
              next_r.retire = 1'b1;
            end
            OP_PC_ADD:
            begin
              // Unsigned offset from the accumulator, taken at issue.
              next_r.pc     = r.pc + PC_W'(r.acc);
              next_r.retire = 1'b1;
            end
            OP_INT_ENABLE:
            begin
              next_r.gie    = 1'b1;
              next_r.pc     = pc_next;
              next_r.retire = 1'b1;
            end
            OP_INT_DISABLE:
            begin
              next_r.gie    = 1'b0;
              next_r.pc     = pc_next;
              next_r.retire = 1'b1;
            end
            default:
            begin
              // Unknown code: treated as a no-operation.
              next_r.pc     = pc_next;
              next_r.retire = 1'b1;
            end
          endcase
        end
      end

      ST_SECOND:
      begin
        // The second instruction cycle of jump or call.
        if (i_instr_en)
        begin
          next_r.extra = r.extra - EXTRA_2T;
          if (r.extra == EXTRA_2T)
          begin
            next_r.st     = ST_IDLE;
            next_r.ready  = 1'b1;
            next_r.retire = 1'b1;
          end
        end
      end

      ST_DELAY:
      begin
        // One step per instruction cycle of this unit, never per core clock.
        if (i_instr_en)
        begin
          if (r.acc <= 8'h01)
          begin
            // Last waiting cycle; a zero written from outside also ends the wait.
            next_r.acc    = ACC_ZERO;
            next_r.st     = ST_IDLE;
            next_r.ready  = 1'b1;
            next_r.retire = 1'b1;
          end
          else
          begin
            next_r.acc = r.acc - 8'h01;
          end
        end
      end

      default:
      begin
        next_r.st    = ST_IDLE;
        next_r.ready = 1'b1;
      end
    endcase

    // A write from outside (an interrupt handler, say) lands in the
    // accumulator last, so during a delay it becomes the new remaining count.
    if (i_acc_wr)
    begin
      next_r.acc = i_acc_wdata;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.ready  <= 1'b1;
      r.pc     <= PC_RST;
      r.sp     <= SP_RST;
      r.acc    <= ACC_RST;
      r.flags  <= FLAGS_RST;
      r.gie    <= GIE_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register.
  assign o_ready       = r.ready;
  assign o_retire      = r.retire;
  assign o_unsupported = r.unsup;
  assign o_pc          = r.pc;
  assign o_sp          = r.sp;
  assign o_acc         = r.acc;
  assign o_flags       = r.flags;
  assign o_gie         = r.gie;

endmodule // system_control_instruction_unit

// >>> sys_ctrl_pkg.sv
// Package for the system-control instruction unit: widths, reset values,
// operation codes, state encodings and the carrier structs.
// Assumes the decoder upstream already maps instruction words onto op_t.
package sys_ctrl_pkg;

  // Width of the program counter; covers the full program space.
  localparam int unsigned PC_W        = 12;
  // Width of the data path, accumulator and stack pointer.
  localparam int unsigned DATA_W      = 8;
  // Number of return-address entries held in the stack store.
  localparam int unsigned STACK_WORDS = 16;
  // Index width into the stack store.
  localparam int unsigned STACK_IDX_W = $clog2(STACK_WORDS);
  // Low bit of the stack pointer that selects an entry (entries are 2 bytes).
  localparam int unsigned SP_IDX_LSB  = 1;

  // Step applied to the stack pointer by a call or a return.
  localparam logic [DATA_W-1:0] SP_STEP    = 8'h02;
  // Step applied to the program counter by an ordinary instruction.
  localparam logic [PC_W-1:0]   PC_STEP    = 12'h001;
  // Values after reset.
  localparam logic [PC_W-1:0]   PC_RST     = 12'h000;
  localparam logic [DATA_W-1:0] SP_RST     = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [3:0]        FLAGS_RST  = 4'h0;
  localparam logic              GIE_RST    = 1'b0;
  // Accumulator value left behind by every delay form.
  localparam logic [DATA_W-1:0] ACC_ZERO   = 8'h00;
  // Extra instruction cycles spent by a two-cycle instruction.
  localparam logic [1:0]        EXTRA_2T   = 2'h1;

  // Operations of the system-control group.
  typedef enum logic [3:0] {
    OP_NOP,
    OP_CALL,
    OP_JUMP,
    OP_DELAY_IMM,
    OP_DELAY_ACC,
    OP_DELAY_MEM,
    OP_RET_IMM,
    OP_RET,
    OP_RET_INT,
    OP_PC_ADD,
    OP_INT_ENABLE,
    OP_INT_DISABLE
  } op_t;

  // Execution states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SECOND,
    ST_DELAY
  } state_t;

  // One instruction as handed over by the decoder.
  typedef struct packed {
    op_t               op;      // Operation.
    logic [PC_W-1:0]   target;  // Jump or call target address.
    logic [DATA_W-1:0] imm;     // Immediate byte.
    logic [DATA_W-1:0] mem;     // Byte already read from the addressed data memory.
  } instr_t;

  // Flag bits kept by the core; this group never alters them.
  typedef struct packed {
    logic z;   // Zero.
    logic c;   // Carry.
    logic ac;  // Auxiliary carry.
    logic ov;  // Overflow.
  } flags_t;

endpackage

// >>> system_control_instruction_unit_sva.sv
// Checker for the system-control instruction unit: watches its ports only.
// Assumes one clock and a synchronous active-low reset; attached by bind.
`timescale 1ns/1ps

module sys_ctrl_checker
  import sys_ctrl_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_instr_en,
  input  wire logic              i_single_unit,
  input  wire logic              i_issue,
  input  wire instr_t            i_instr,
  input  wire logic              i_acc_wr,
  input  wire logic              i_flags_wr,
  input  wire logic              o_ready,
  input  wire logic              o_retire,
  input  wire logic              o_unsupported,
  input  wire logic [PC_W-1:0]   o_pc,
  input  wire logic [DATA_W-1:0] o_sp,
  input  wire logic [DATA_W-1:0] o_acc,
  input  wire flags_t            o_flags,
  input  wire logic              o_gie
);
  // High at an edge where the unit accepts an instruction.
  logic take;
  assign take = i_issue && i_instr_en && o_ready;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_call_push_jump: assert property (
    take && i_instr.op == OP_CALL |=> o_pc == $past(i_instr.target) && o_sp == $past(o_sp) + SP_STEP)
    else $error("call did not load pc or step sp");
  a_jump_two_cycle: assert property (
    take && i_instr.op == OP_JUMP |=> !o_ready && o_pc == $past(i_instr.target))
    else $error("jump did not load pc in two cycles");
  a_ret_sp_drop: assert property (
    take && i_instr.op == OP_RET |=> o_sp == $past(o_sp) - SP_STEP)
    else $error("return did not lower sp by two");
  a_ret_value_acc: assert property (
    take && i_instr.op == OP_RET_IMM && !i_acc_wr |=> o_acc == $past(i_instr.imm))
    else $error("return with value left wrong accumulator");
  a_reti_sets_gie: assert property (
    take && i_instr.op == OP_RET_INT |=> o_gie)
    else $error("interrupt return left enable low");
  a_gie_enable: assert property (
    take && i_instr.op == OP_INT_ENABLE |=> o_gie)
    else $error("enable instruction left enable low");
  a_gie_disable: assert property (
    take && i_instr.op == OP_INT_DISABLE |=> !o_gie)
    else $error("disable instruction left enable high");
  a_pc_add_sum: assert property (
    take && i_instr.op == OP_PC_ADD |=> o_pc == $past(o_pc) + {4'h0, $past(o_acc)})
    else $error("computed branch gave wrong pc");
  a_nop_pc_step: assert property (
    take && i_instr.op == OP_NOP |=> o_pc == $past(o_pc) + PC_STEP && $stable(o_sp))
    else $error("no-operation changed more than pc");
  a_single_refuse: assert property (
    take && i_single_unit && i_instr.op inside {OP_DELAY_IMM, OP_DELAY_ACC, OP_DELAY_MEM}
    |=> o_unsupported && o_retire)
    else $error("delay in single-unit mode not refused");
  a_flags_kept: assert property (
    !i_flags_wr |=> $stable(o_flags))
    else $error("flags changed without a flag write");
  // Main scenarios seen at least once.
  c_call: cover property (take && i_instr.op == OP_CALL);
  c_delay: cover property (take && i_instr.op == OP_DELAY_MEM);
  c_reti: cover property (take && i_instr.op == OP_RET_INT);
endmodule // sys_ctrl_checker

bind system_control_instruction_unit sys_ctrl_checker chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_instr_en(i_instr_en), .i_single_unit(i_single_unit),
  .i_issue(i_issue), .i_instr(i_instr), .i_acc_wr(i_acc_wr), .i_flags_wr(i_flags_wr), .o_ready(o_ready),
  .o_retire(o_retire), .o_unsupported(o_unsupported), .o_pc(o_pc), .o_sp(o_sp), .o_acc(o_acc),
  .o_flags(o_flags), .o_gie(o_gie));

// >>> system_control_instruction_unit_test.sv
// Self-checking bench for the system-control instruction unit.
// Assumes the instruction-cycle enable is high except where a scenario stalls it.
`timescale 1ns/1ps

module system_control_instruction_unit_test;
  import sys_ctrl_pkg::*;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_instr_en = 1'b1, i_single_unit = 1'b0, i_issue = 1'b0;
  logic i_acc_wr = 1'b0, i_flags_wr = 1'b0, o_ready, o_retire, o_unsupported, o_gie;
  instr_t            i_instr = '0;
  logic [DATA_W-1:0] i_acc_wdata = 8'h00, o_sp, o_acc;
  flags_t            i_flags_wdata = '0, o_flags;
  logic [PC_W-1:0]   o_pc;
  int                mismatches = 0, tests_run = 0, n;
  system_control_instruction_unit dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_instr_en(i_instr_en),
    .i_single_unit(i_single_unit), .i_issue(i_issue), .i_instr(i_instr), .i_acc_wr(i_acc_wr),
    .i_acc_wdata(i_acc_wdata), .i_flags_wr(i_flags_wr), .i_flags_wdata(i_flags_wdata), .o_ready(o_ready),
    .o_retire(o_retire), .o_unsupported(o_unsupported), .o_pc(o_pc), .o_sp(o_sp), .o_acc(o_acc),
    .o_flags(o_flags), .o_gie(o_gie));
  // Free-running 125 MHz clock.
  initial forever #4 i_core_clk = ~i_core_clk;
  // Counts one comparison and reports a mismatch.
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Issues one instruction and counts edges from the taking edge to retire.
  task automatic exec(input op_t op, input logic [PC_W-1:0] t, input logic [DATA_W-1:0] imm, mem);
    @(posedge i_core_clk);
    i_issue <= 1'b1;
    i_instr <= '{op, t, imm, mem};
    @(posedge i_core_clk);
    i_issue <= 1'b0;
    // The taking edge counts as the first; a one-cycle op retires right after it.
    n = 1;
    #1;
    while (o_retire !== 1'b1 && n < 400)
    begin
      @(posedge i_core_clk);
      n++;
      #1;
    end
    chk(o_retire === 1'b1, "no retire");
  endtask
  // Writes the accumulator from outside for one cycle.
  task automatic set_acc(input logic [DATA_W-1:0] v);
    @(posedge i_core_clk);
    i_acc_wr    <= 1'b1;
    i_acc_wdata <= v;
    @(posedge i_core_clk);
    i_acc_wr <= 1'b0;
  endtask
  // Jumps, then calls twice and returns through return-with-value and plain return.
  task automatic t_flow;
    exec(OP_NOP, 12'h000, 8'h00, 8'h00);
    chk(n == 1 && o_pc === 12'h001 && o_sp === 8'h00, "nop");
    exec(OP_JUMP, 12'hFFF, 8'h00, 8'h00);
    chk(n == 2 && o_pc === 12'hFFF, "jump top");
    exec(OP_JUMP, 12'h100, 8'h00, 8'h00);
    exec(OP_CALL, 12'h200, 8'h00, 8'h00);
    chk(n == 2 && o_pc === 12'h200 && o_sp === 8'h02, "call");
    exec(OP_CALL, 12'h300, 8'h00, 8'h00);
    chk(o_pc === 12'h300 && o_sp === 8'h04, "nested call");
    exec(OP_RET_IMM, 12'h000, 8'h55, 8'h00);
    chk(n == 1 && o_acc === 8'h55 && o_sp === 8'h02 && o_pc === 12'h201, "ret value");
    exec(OP_RET, 12'h000, 8'h00, 8'h00);
    chk(o_pc === 12'h101 && o_sp === 8'h00, "ret");
  endtask
  // Global enable, interrupt return and computed branch.
  task automatic t_gie;
    exec(OP_INT_ENABLE, 12'h000, 8'h00, 8'h00);
    chk(o_gie === 1'b1, "enable");
    exec(OP_INT_DISABLE, 12'h000, 8'h00, 8'h00);
    chk(o_gie === 1'b0, "disable");
    exec(OP_CALL, 12'h040, 8'h00, 8'h00);
    exec(OP_RET_INT, 12'h000, 8'h00, 8'h00);
    chk(o_gie === 1'b1 && o_pc === 12'h104 && o_sp === 8'h00, "reti");
    set_acc(8'h03);
    exec(OP_PC_ADD, 12'h000, 8'h00, 8'h00);
    chk(o_pc === 12'h107, "pcadd");
  endtask
  // All delay forms, a disturbed delay and a refused one.
  task automatic t_delay;
    exec(OP_DELAY_IMM, 12'h000, 8'h00, 8'h00);
    chk(n == 1 && o_acc === 8'h00, "delay imm 0");
    exec(OP_DELAY_IMM, 12'h000, 8'h05, 8'h00);
    chk(n == 6 && o_acc === 8'h00, "delay imm 5");
    set_acc(8'h0F);
    exec(OP_DELAY_ACC, 12'h000, 8'h00, 8'h00);
    chk(n == 16 && o_acc === 8'h00, "delay acc");
    exec(OP_DELAY_MEM, 12'h000, 8'h00, 8'hFF);
    chk(n == 256 && o_acc === 8'h00, "delay mem");
    fork
      exec(OP_DELAY_IMM, 12'h000, 8'h14, 8'h00);
      begin
        repeat (5) @(posedge i_core_clk);
        set_acc(8'h02);
      end
    join
    chk(n == 8 && o_acc === 8'h00, "disturbed delay");
    fork
      exec(OP_DELAY_IMM, 12'h000, 8'h03, 8'h00);
      begin
        repeat (2) @(posedge i_core_clk);
        i_instr_en <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_instr_en <= 1'b1;
      end
    join
    chk(n == 8 && o_acc === 8'h00, "delay counts unit cycles");
    @(posedge i_core_clk);
    i_single_unit <= 1'b1;
    set_acc(8'h07);
    exec(OP_DELAY_IMM, 12'h000, 8'h05, 8'h00);
    chk(n == 1 && o_unsupported === 1'b1 && o_acc === 8'h07, "single unit");
    @(posedge i_core_clk);
    i_single_unit <= 1'b0;
    chk(o_flags === flags_t'(4'hA), "flags kept");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  // Main sequence: reset, reset values, flag preload, scenarios.
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1;
    chk(o_pc === PC_RST && o_sp === SP_RST && o_acc === ACC_RST && o_gie === GIE_RST && o_ready === 1'b1,
        "reset values");
    @(posedge i_core_clk);
    i_flags_wr    <= 1'b1;
    i_flags_wdata <= flags_t'(4'hA);
    @(posedge i_core_clk);
    i_flags_wr <= 1'b0;
    t_flow();
    t_gie();
    t_delay();
    close_out();
  end
endmodule // system_control_instruction_unit_test
